// [hw/fes_params.svh]
`ifndef FES_PARAMS_SVH
`define FES_PARAMS_SVH
// register byte offsets
`define FES_OFF_CTRL 12'h000
`define FES_OFF_STAT 12'h004
`define FES_OFF_CODE 12'h008
`define FES_OFF_IRQ_STAT 12'h00C
`define FES_OFF_IRQ_MASK 12'h010
`define FES_OFF_WDT_MAX 12'h014
`define FES_OFF_SCAN 12'h018
// fault codes
`define FES_CODE_NONE 8'h00
`define FES_CODE_MEM 8'hF1
`define FES_CODE_NOEND 8'hF0
`define FES_CODE_BUS 8'hC0
`define FES_CODE_CONFLICT 8'hE1
`define FES_CODE_IOTAB 8'hE0
`define FES_CODE_STOP_SYS 8'h9F
`define FES_STOP_MIN 8'h01
`define FES_STOP_MAX 8'h99
// timing
`define FES_CLK_HZ 25000000
`define FES_PWR_LOSS_MS 10
`define FES_WDT_DEF_MS 130
`define FES_SLOW_LO_MS 120
`define FES_SLOW_HI_MS 130
`define FES_CYC_PER_MS (`FES_CLK_HZ / 1000)
`define FES_PWR_LOSS_CYC (`FES_PWR_LOSS_MS * `FES_CYC_PER_MS)
`define FES_WDT_DEF_CYC (`FES_WDT_DEF_MS * `FES_CYC_PER_MS)
`define FES_SLOW_LO_CYC (`FES_SLOW_LO_MS * `FES_CYC_PER_MS)
`define FES_SLOW_HI_CYC (`FES_SLOW_HI_MS * `FES_CYC_PER_MS)
// status bit positions; fault number sits in bits 7..0 of the status area word
`define FES_STAT_FATAL 8
`define FES_STAT_PWR 9
`define FES_MODE_PROG 2'h0
// sticky event bit positions, shared by the interrupt status and mask words
`define FES_EV_HALT 0
`define FES_EV_PWR 1
`define FES_EV_WDT 2
`define FES_EV_REFUSED 3
// control word bit that asks for a clear and restart
`define FES_CTRL_CLEAR 0
`endif

// [hw/fes_pkg.sv]
package fes_pkg;
  typedef enum logic [3:0] {
    FES_RUN = 4'h1,
    FES_HALT = 4'h2,
    FES_PWR_OFF = 4'h4,
    FES_IDLE = 4'h8
  } fes_state_type;

  // scan engine reports
  typedef struct packed {
    logic mem_fault;
    logic no_end;
    logic bus_fault;
    logic [1:0] bus_rack;
    logic unit_conflict;
    logic hd64_num9;
    logic link_level_dup;
    logic iotab_mismatch;
    logic stop_exec;
    logic [7:0] stop_code;
    logic scan_end;
  } fes_scan_type;

  // front indicators and run output
  typedef struct packed {
    logic power_led;
    logic alarm_led;
    logic run_out;
    logic outputs_off;
    logic halt;
  } fes_front_type;
endpackage

// [hw/fes_supervisor.sv]
// Function
// - any fatal error halts execution and forces every output off
// - power interruption leaves all front indicators dark
// - other fatal errors light power and alarm indicators
// - run output stays low while a fatal error is active
// - supply loss of 10 ms or more is fatal, no fault code
// - watchdog over its maximum (default 130 ms) is fatal, no code
// - memory unit absent, checksum or illegal instruction reports F1
// - program without end instruction reports F0
// - I/O bus fault reports C0 to C3, low digit is rack
// - duplicated unit or I/O numbers report E1
// - 64-point high-density unit on I/O number 9 reports E1
// - two link units on one operating level report E1
// - I/O table words disagreeing with mounted units report E0
// - fatal stop instruction reports its user code 01 to 99; the code is passed on unchecked, with no range test
// - fatal stop with scan time 120 to 130 ms reports 9F
// - fault code copied into the readable system status area
// - fault number field is status bits 00 to 07 of word 253
// - stored errors clear only in program mode
`timescale 1ns/1ps
`default_nettype none
`include "fes_params.svh"
module fes_supervisor (
  // bus clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // scan engine, same clock
  input wire fes_pkg::fes_scan_type scan,
  input wire logic [1:0] mode,
  // supply monitor pin, asynchronous
  input wire logic supply_ok_pin,
  // front panel and interrupt
  output fes_pkg::fes_front_type front,
  output logic irq
);

  // supply pin synchroniser, first stage read only by the second
  logic sup_meta_ff;
  logic sup_sync_ff;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sup_meta_ff <= 1'b1;
      sup_sync_ff <= 1'b1;
    end
    else
    begin
      sup_meta_ff <= supply_ok_pin;
      sup_sync_ff <= sup_meta_ff;
    end
  end

  // registers
  fes_pkg::fes_state_type state_ff;
  fes_pkg::fes_state_type nxt_state;
  logic [7:0] code_ff;
  logic [7:0] nxt_code;
  logic [23:0] loss_cnt_ff;
  logic [23:0] scan_cnt_ff;
  logic [23:0] last_scan_ff;
  logic [23:0] wdt_max_ff;
  logic [3:0] irq_stat_ff;
  logic [3:0] irq_mask_ff;
  logic restart_ff;
  fes_pkg::fes_front_type front_ff;
  logic irq_ff;

  // ahb address phase capture
  logic ap_valid_ff;
  logic ap_write_ff;
  logic [11:0] ap_addr_ff;
  logic [31:0] hrdata_ff;
  wire ap_take = hsel & hready & htrans[1];
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ap_valid_ff <= 1'b0;
      ap_write_ff <= 1'b0;
      ap_addr_ff <= 12'h000;
    end
    else
    begin
      ap_valid_ff <= ap_take;
      ap_write_ff <= hwrite;
      ap_addr_ff <= haddr;
    end
  end

  // write decode in data phase
  wire wr_phase = ap_valid_ff & ap_write_ff;
  wire wr_ctrl = wr_phase & (ap_addr_ff == `FES_OFF_CTRL);
  wire wr_mask = wr_phase & (ap_addr_ff == `FES_OFF_IRQ_MASK);
  wire wr_wdt = wr_phase & (ap_addr_ff == `FES_OFF_WDT_MAX);
  wire prog_mode = (mode == `FES_MODE_PROG);
  // clearing refused outside program mode
  wire clear_bit = hwdata[`FES_CTRL_CLEAR];
  wire clear_req = wr_ctrl & clear_bit & prog_mode;
  // read decode in address phase, data registered for the data phase
  wire rd_take = ap_take & ~hwrite;
  wire rd_istat = rd_take & (haddr == `FES_OFF_IRQ_STAT);

  // state decode shared by the sequencer, the counters and the status word;
  // one-hot codes keep each compare to a single flop in practice
  wire st_run = (state_ff == fes_pkg::FES_RUN);
  wire st_halt = (state_ff == fes_pkg::FES_HALT);
  wire st_pwr = (state_ff == fes_pkg::FES_PWR_OFF);
  wire fatal_now = st_halt | st_pwr;

  // supply loss timer, only a loss of the full length counts
  wire loss_done = (loss_cnt_ff >= 24'(`FES_PWR_LOSS_CYC - 1));
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      loss_cnt_ff <= 24'h000000;
    else if (sup_sync_ff)
      loss_cnt_ff <= 24'h000000;
    else if (!loss_done)
      loss_cnt_ff <= loss_cnt_ff + 24'h000001;
  end
  wire pwr_fail = ~sup_sync_ff & loss_done;

  // scan watchdog; frozen while halted and cleared by a restart, so a
  // recovered program is not tripped again by the stale count
  wire wdt_trip = (scan_cnt_ff > wdt_max_ff);
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      scan_cnt_ff <= 24'h000000;
    else if (scan.scan_end || restart_ff)
      scan_cnt_ff <= 24'h000000;
    else if (!fatal_now && !wdt_trip)
      scan_cnt_ff <= scan_cnt_ff + 24'h000001;
  end

  // length of the last completed scan, used by the slow stop check
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      last_scan_ff <= 24'h000000;
    else if (scan.scan_end)
      last_scan_ff <= scan_cnt_ff;
  end

  // the user code is taken as given; a slow scan overrides it with 9F
  wire slow_scan = (last_scan_ff >= 24'(`FES_SLOW_LO_CYC))
    & (last_scan_ff <= 24'(`FES_SLOW_HI_CYC));
  wire conflict = scan.unit_conflict | scan.hd64_num9 | scan.link_level_dup;
  wire any_code_fault = scan.mem_fault | scan.no_end | scan.bus_fault | conflict
    | scan.iotab_mismatch | scan.stop_exec;
  wire run_fault = any_code_fault | wdt_trip;

  // priority: memory, no end, bus, conflict, table, stop
  always_comb
  begin
    nxt_code = code_ff;
    if (scan.mem_fault)
      nxt_code = `FES_CODE_MEM;
    else if (scan.no_end)
      nxt_code = `FES_CODE_NOEND;
    else if (scan.bus_fault)
      nxt_code = `FES_CODE_BUS | {6'h00, scan.bus_rack};
    else if (conflict)
      nxt_code = `FES_CODE_CONFLICT;
    else if (scan.iotab_mismatch)
      nxt_code = `FES_CODE_IOTAB;
    else if (scan.stop_exec)
      nxt_code = slow_scan ? `FES_CODE_STOP_SYS : scan.stop_code;
    else if (wdt_trip)
      nxt_code = `FES_CODE_NONE;
  end

  // supervisor state: once halted only a supply loss, power-up or a program-mode restart leaves
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      fes_pkg::FES_IDLE:
        nxt_state = fes_pkg::FES_RUN;
      fes_pkg::FES_RUN:
        if (pwr_fail)
          nxt_state = fes_pkg::FES_PWR_OFF;
        else if (run_fault)
          nxt_state = fes_pkg::FES_HALT;
      fes_pkg::FES_HALT:
        if (pwr_fail)
          nxt_state = fes_pkg::FES_PWR_OFF;
        else if (restart_ff)
          nxt_state = fes_pkg::FES_IDLE;
      fes_pkg::FES_PWR_OFF:
        if (restart_ff && sup_sync_ff)
          nxt_state = fes_pkg::FES_IDLE;
      default:
        nxt_state = fes_pkg::FES_IDLE;
    endcase
  end

  wire enter_halt = st_run & ~pwr_fail & run_fault;
  wire enter_pwr = ~st_pwr & pwr_fail;

  // supervisor state register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      state_ff <= fes_pkg::FES_IDLE;
    else
      state_ff <= nxt_state;
  end

  // restart request; a clear only counts while a fatal error is latched
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      restart_ff <= 1'b0;
    else
      restart_ff <= clear_req & fatal_now;
  end

  // fault code; a new fault wins over a clear landing in the same cycle
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      code_ff <= `FES_CODE_NONE;
    else if (enter_pwr)
      code_ff <= `FES_CODE_NONE;
    else if (enter_halt)
      code_ff <= nxt_code;
    else if (clear_req)
      code_ff <= `FES_CODE_NONE;
  end

  // indicator pattern from the next state so outputs follow in one cycle
  wire nxt_halted = (nxt_state == fes_pkg::FES_HALT);
  wire nxt_pwr = (nxt_state == fes_pkg::FES_PWR_OFF);
  wire nxt_running = (nxt_state == fes_pkg::FES_RUN);
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      front_ff <= '0;
    else
    begin
      front_ff.power_led <= ~nxt_pwr;
      front_ff.alarm_led <= nxt_halted;
      front_ff.run_out <= nxt_running;
      front_ff.outputs_off <= ~nxt_running;
      // halt marks a latched fatal error only, not the single idle cycle of a
      // restart, so the indicator pattern always matches the halt flag
      front_ff.halt <= nxt_halted | nxt_pwr;
    end
  end
  assign front = front_ff;

  // sticky events: halt, power, watchdog and refused clear
  wire [3:0] ev;
  assign ev[`FES_EV_HALT] = enter_halt;
  assign ev[`FES_EV_PWR] = enter_pwr;
  assign ev[`FES_EV_WDT] = wdt_trip & enter_halt;
  assign ev[`FES_EV_REFUSED] = wr_ctrl & clear_bit & ~prog_mode;

  // one slice per status bit; the set wins over the read clear so no event is lost
  wire [3:0] nxt_irq_stat;
  wire [3:0] nxt_irq_mask;
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1)
    begin : g_evbit
      assign nxt_irq_stat[gi] = (irq_stat_ff[gi] & ~rd_istat) | ev[gi];
      assign nxt_irq_mask[gi] = wr_mask ? hwdata[gi] : irq_mask_ff[gi];
    end
  endgenerate

  // status and mask registers with the level interrupt
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      irq_stat_ff <= 4'h0;
      irq_mask_ff <= 4'h0;
      irq_ff <= 1'b0;
    end
    else
    begin
      irq_stat_ff <= nxt_irq_stat;
      irq_mask_ff <= nxt_irq_mask;
      // built from next values so irq moves on the same edge as its status bit
      irq_ff <= |(nxt_irq_stat & nxt_irq_mask);
    end
  end
  assign irq = irq_ff;

  // watchdog limit in cycles; a small value lets software exercise the trip
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      wdt_max_ff <= 24'(`FES_WDT_DEF_CYC);
    else if (wr_wdt)
      wdt_max_ff <= hwdata[23:0];
  end

  // read mux, status word holds the fault number in its low byte
  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = 32'h00000000;
    case (haddr)
      `FES_OFF_STAT:
      begin
        rd_mux[7:0] = code_ff;
        rd_mux[`FES_STAT_FATAL] = fatal_now;
        rd_mux[`FES_STAT_PWR] = (state_ff == fes_pkg::FES_PWR_OFF);
      end
      `FES_OFF_CODE: rd_mux[7:0] = code_ff;
      `FES_OFF_IRQ_STAT: rd_mux[3:0] = irq_stat_ff;
      `FES_OFF_IRQ_MASK: rd_mux[3:0] = irq_mask_ff;
      `FES_OFF_WDT_MAX: rd_mux[23:0] = wdt_max_ff;
      `FES_OFF_SCAN: rd_mux[23:0] = last_scan_ff;
      default: rd_mux = 32'h00000000;
    endcase
  end
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata_ff <= 32'h00000000;
    else if (rd_take)
      hrdata_ff <= rd_mux;
  end
  assign hrdata = hrdata_ff;
  // response flops; zero wait and always OKAY, but registered like every
  // other output so the bus sees no combinational path out of the block
  logic hreadyout_ff;
  logic hresp_ff;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout_ff <= 1'b1;
      hresp_ff <= 1'b0;
    end
    else
    begin
      hreadyout_ff <= 1'b1;
      hresp_ff <= 1'b0;
    end
  end
  assign hreadyout = hreadyout_ff;
  assign hresp = hresp_ff;

endmodule
`default_nettype wire

// [test/fes_supervisor_checker.sv]
`timescale 1ns/1ps
`default_nettype none
module fes_supervisor_checker (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // watched ports
  input wire fes_pkg::fes_scan_type scan,
  input wire logic [1:0] mode,
  input wire fes_pkg::fes_front_type front
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // any of the three unit clashes
  wire clash = scan.unit_conflict | scan.hd64_num9 | scan.link_level_dup;
  // a fault seen while running halts with the alarm lit one edge later
  property stops(f);
    f && front.run_out |=> front.halt && front.alarm_led;
  endproperty
  mem_stop_a: assert property (stops(scan.mem_fault)) else $error("mem no halt");
  noend_stop_a: assert property (stops(scan.no_end)) else $error("noend no halt");
  bus_stop_a: assert property (stops(scan.bus_fault)) else $error("bus no halt");
  unit_clash_a: assert property (stops(clash))
    else $error("clash no halt");
  iotab_stop_a: assert property (stops(scan.iotab_mismatch)) else $error("iotab");
  user_stop_a: assert property (stops(scan.stop_exec)) else $error("stop no halt");
  // halted means outputs forced off and run output low
  halt_off_a: assert property (front.halt |-> front.outputs_off && !front.run_out)
    else $error("outputs live in halt");
  led_pair_a: assert property (front.halt |-> front.alarm_led == front.power_led)
    else $error("led pattern");
  // halt only leaves through program mode
  clear_mode_a: assert property ($fell(front.halt) |-> $past(mode) == 2'h0)
    else $error("cleared outside program");
  halt_hold_a: assert property (front.halt && mode != 2'h0 |=> front.halt)
    else $error("halt dropped");
  cover property (front.halt && front.power_led);
  cover property (front.halt && !front.power_led);
  cover property ($fell(front.halt));
endmodule
`default_nettype wire

// [test/fes_scan_model.sv]
`timescale 1ns/1ps
`default_nettype none
module fes_scan_model (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // program behaviour chosen by the bench
  input wire fes_pkg::fes_scan_type req,
  input wire logic [23:0] scan_len,
  // toward the supervisor
  output fes_pkg::fes_scan_type scan
);
  logic [23:0] cnt_ff;
  logic [23:0] nxt_cnt;
  logic done;
  // zero length never ends a scan, so the watchdog starves
  // a shortened length ends the running scan at once
  assign done = (scan_len != 24'h0) && (cnt_ff >= scan_len);
  assign nxt_cnt = done ? 24'h0 : cnt_ff + 24'h1;
  // scan length counter
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      cnt_ff <= 24'h0;
    else
      cnt_ff <= nxt_cnt;
  end
  // a stop is dropped when its code is 00; any other code passes through
  always_comb
  begin
    scan = req;
    scan.stop_exec = req.stop_exec && (req.stop_code != 8'h00);
    scan.scan_end = done;
  end
endmodule
`default_nettype wire

// [test/fes_supervisor_test.sv]
`timescale 1ns/1ps
`default_nettype none
module fes_supervisor_test;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic [1:0] mode = 2'h0;
  logic supply_ok_pin = 1'b1;
  logic [23:0] scan_len = 24'h20;
  logic irq;
  logic [31:0] q;
  fes_pkg::fes_scan_type req = '0;
  fes_pkg::fes_scan_type scan;
  fes_pkg::fes_front_type front;
  int err_total = 0;
  int compares = 0;
  // fault request beside the code it must report
  logic [26:0] rows [9] = '{
    {19'h40000, 8'hF1},
    {19'h20000, 8'hF0},
    {19'h10000, 8'hC0},
    {19'h18000, 8'hC2},
    {19'h02000, 8'hE1},
    {19'h01000, 8'hE1},
    {19'h00800, 8'hE1},
    {19'h00400, 8'hE0},
    {19'h00284, 8'h42}};
  always #20 hclk = ~hclk;
  fes_scan_model u_prog (.hclk(hclk), .hresetn(hresetn), .req(req), .scan_len(scan_len),
    .scan(scan));
  fes_supervisor u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .scan(scan), .mode(mode),
    .supply_ok_pin(supply_ok_pin), .front(front), .irq(irq));
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  // one single transfer; the slave may stretch either phase
  task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    q = hrdata;
  endtask
  // raise one fault for two cycles and let the halt land
  task hit(input logic [18:0] f);
    req <= f;
    repeat (2) @(posedge hclk);
    req <= '0;
  endtask
  task finish_test;
    $display("compares %0d errors %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    repeat (12) @(posedge hclk);
    chk("reset", {27'h0, front}, 32'h0);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    chk("run", {27'h0, front}, 32'h14);
    bus(1'b0, 12'h014, 32'h0);
    chk("wdt_max", q, 32'h319750);
    bus(1'b0, 12'h020, 32'h0);
    chk("unmapped", q, 32'h0);
    bus(1'b1, 12'h010, 32'hF);
    for (int i = 0; i < 9; i++)
    begin
      hit(rows[i][26:8]);
      chk("halted", {27'h0, front}, 32'h1B);
      chk("irq", {31'h0, irq}, 32'h1);
      bus(1'b0, 12'h004, 32'h0);
      chk("stat", q, {24'h1, rows[i][7:0]});
      bus(1'b0, 12'h00C, 32'h0);
      chk("irq_stat", q, 32'h1);
      bus(1'b1, 12'h000, 32'h1);
      repeat (4) @(posedge hclk);
      chk("restart", {27'h0, front}, 32'h14);
      chk("irq_clr", {31'h0, irq}, 32'h0);
    end
    // clear refused outside program mode, halt stays
    hit(19'h40000);
    mode <= 2'h1;
    bus(1'b1, 12'h000, 32'h1);
    repeat (4) @(posedge hclk);
    chk("held", {27'h0, front}, 32'h1B);
    bus(1'b0, 12'h00C, 32'h0);
    chk("refused", q, 32'h9);
    mode <= 2'h0;
    bus(1'b1, 12'h000, 32'h1);
    // short supply dip is not fatal
    supply_ok_pin <= 1'b0;
    repeat (1000) @(posedge hclk);
    supply_ok_pin <= 1'b1;
    repeat (4) @(posedge hclk);
    chk("dip", {27'h0, front}, 32'h14);
    // starved watchdog with its interrupt masked
    scan_len <= 24'h0;
    bus(1'b1, 12'h010, 32'h0);
    bus(1'b1, 12'h014, 32'h64);
    repeat (200) @(posedge hclk);
    chk("wdt_halt", {27'h0, front}, 32'h1B);
    chk("masked", {31'h0, irq}, 32'h0);
    bus(1'b0, 12'h004, 32'h0);
    chk("wdt_code", q, 32'h100);
    bus(1'b0, 12'h00C, 32'h0);
    chk("wdt_stat", q, 32'h5);
    // restart after a watchdog trip, scans running again
    scan_len <= 24'h20;
    bus(1'b1, 12'h000, 32'h1);
    repeat (4) @(posedge hclk);
    chk("wdt_restart", {27'h0, front}, 32'h14);
    bus(1'b0, 12'h004, 32'h0);
    chk("stat_clr", q, 32'h0);
    // reset in mid-run acts as power-up
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    chk("rst_mid", {27'h0, front}, 32'h0);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    chk("rst_run", {27'h0, front}, 32'h14);
    bus(1'b0, 12'h014, 32'h0);
    chk("rst_wdt", q, 32'h319750);
    chk("hresp", {31'h0, hresp}, 32'h0);
    finish_test;
  end
  initial
  begin
    repeat (20000) @(posedge hclk);
    err_total++;
    finish_test;
  end
endmodule
bind fes_supervisor fes_supervisor_checker u_chk (.hclk(hclk), .hresetn(hresetn),
  .scan(scan), .mode(mode), .front(front));
`default_nettype wire
